// >>> gpts_pkg.sv
// package for the general purpose timer set
package gpts_pkg;
  localparam logic [11:0] off_t1_con = 12'h000;
  localparam logic [11:0] off_t1_cnt = 12'h004;
  localparam logic [11:0] off_t1_per = 12'h008;
  localparam logic [11:0] off_status = 12'h00c;
  localparam logic [11:0] off_irq_en = 12'h010;
  localparam logic [11:0] off_idle = 12'h014;
  localparam logic [11:0] off_pair_base = 12'h040;
  localparam logic [11:0] pair_stride = 12'h040;
  localparam logic [11:0] off_lo_con = 12'h000;
  localparam logic [11:0] off_hi_con = 12'h004;
  localparam logic [11:0] off_lo_cnt = 12'h008;
  localparam logic [11:0] off_hi_cnt = 12'h00c;
  localparam logic [11:0] off_lo_per = 12'h010;
  localparam logic [11:0] off_hi_per = 12'h014;
  localparam int bit_on = 15;
  localparam int bit_sidl = 13;
  localparam int bit_gate = 6;
  localparam int bit_ps_hi = 5;
  localparam int bit_ps_lo = 4;
  localparam int bit_join = 3;
  localparam int bit_sync = 2;
  localparam int bit_cs = 1;
  localparam logic [15:0] t1_con_mask = 16'ha076;
  localparam logic [15:0] lo_con_mask = 16'ha07a;
  localparam logic [15:0] hi_con_mask = 16'ha072;
  localparam logic [15:0] con_reset = 16'h0000;
  localparam logic [15:0] cnt_reset = 16'h0000;
  localparam logic [15:0] per_reset = 16'hffff;
  localparam logic [7:0] ps_div1 = 8'h00;
  localparam logic [7:0] ps_div8 = 8'h07;
  localparam logic [7:0] ps_div64 = 8'h3f;
  localparam logic [7:0] ps_div256 = 8'hff;
  typedef struct packed {
    logic ext_clk;
    logic gate;
  } gpts_tin_t;
endpackage

// >>> gpts_top.sv
// general purpose timer set: standalone timer plus two joinable pairs
// Function
// - standalone timer counts only while timer_on is set
// - stop_in_idle halts the timer while device idle except in async counter mode, else keeps running
// - internal clock with gate enable counts only while gate high
// - prescale codes 11,10,01,00 divide by 256,64,8,1
// - ext_clock_sync chooses synchronised or raw external clock counting
// - clock_source_select picks external rising edges or internal clock
// - writing control while running resets the prescale counter
// - interrupt on period match, and gate falling edge in gated mode
// - standalone modes: timer, sync counter, async counter running in idle
// - pair_join_mode on low control joins a pair into 32 bits
// - in joined mode high control bits are ignored
// - joined counter uses low timer clock and gate inputs
// - joined match is flagged on the high timer flag
// - high_count holds upper word, low_count lower word
// - high_period upper, low_period lower; full 32-bit match flags
// - unjoined timers of a pair run with own controls, but a low control write also resets the prescaler of a running high timer
// - pair timers have no sync bit and count raw external edges, but have no idle-proof asynchronous mode
// - only first pair drives adc trigger, from joined or high timer
`timescale 1ns/1ps
`default_nettype none
module gpts_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic device_idle,
  input wire gpts_pkg::gpts_tin_t standalone_in,
  input wire gpts_pkg::gpts_tin_t [1:0] pair_low_in,
  input wire gpts_pkg::gpts_tin_t [1:0] pair_high_in,
  output logic [4:0] irq_flags,
  output logic adc_trigger
);
  // apb slave
  logic [15:0] standalone_timer_control;
  logic [15:0] t1_cnt;
  logic [15:0] standalone_period;
  logic [4:0] standalone_irq_enable;
  logic [4:0] irq_en;
  logic [15:0] con [0:3];
  logic [15:0] cnt [0:3];
  logic [15:0] per [0:3];
  logic [4:0] flag;
  logic wr;
  logic rd;
  logic [4:0] clr;
  logic [3:0] con_wr;
  logic [3:0] cnt_wr;
  logic [3:0] per_wr;
  logic t1_con_wr;
  logic t1_cnt_wr;
  logic t1_per_wr;
  logic [31:0] next_prdata;
  logic next_err;
  logic hit;
  assign wr = psel && penable && pwrite && pready;
  assign rd = psel && penable && !pwrite && !pready;
  assign standalone_irq_enable = irq_en;

  function automatic logic [7:0] ps_limit(input logic [1:0] code);
    unique case (code)
      2'b11: ps_limit = gpts_pkg::ps_div256;
      2'b10: ps_limit = gpts_pkg::ps_div64;
      2'b01: ps_limit = gpts_pkg::ps_div8;
      default: ps_limit = gpts_pkg::ps_div1;
    endcase
  endfunction

  function automatic logic [11:0] pair_addr(input int p, input logic [11:0] o);
    pair_addr = 12'(gpts_pkg::off_pair_base + 12'(p) * gpts_pkg::pair_stride
      + o);
  endfunction

  // register decode
  always_comb begin
    next_prdata = 32'h0000_0000;
    hit = 1'b0;
    t1_con_wr = 1'b0;
    t1_cnt_wr = 1'b0;
    t1_per_wr = 1'b0;
    con_wr = 4'h0;
    cnt_wr = 4'h0;
    per_wr = 4'h0;
    clr = 5'h00;
    if (paddr == gpts_pkg::off_t1_con) begin
      hit = 1'b1;
      next_prdata = {16'h0000, standalone_timer_control};
      t1_con_wr = wr;
    end else if (paddr == gpts_pkg::off_t1_cnt) begin
      hit = 1'b1;
      next_prdata = {16'h0000, t1_cnt};
      t1_cnt_wr = wr;
    end else if (paddr == gpts_pkg::off_t1_per) begin
      hit = 1'b1;
      next_prdata = {16'h0000, standalone_period};
      t1_per_wr = wr;
    end else if (paddr == gpts_pkg::off_status) begin
      hit = 1'b1;
      next_prdata = {27'h0000000, flag};
      clr = wr ? pwdata[4:0] : 5'h00;
    end else if (paddr == gpts_pkg::off_irq_en) begin
      hit = 1'b1;
      next_prdata = {27'h0000000, irq_en};
    end else if (paddr == gpts_pkg::off_idle) begin
      hit = 1'b1;
      next_prdata = {31'h00000000, device_idle};
    end
    for (int i = 0; i < 4; i++) begin
      if (paddr == pair_addr(i / 2, i[0] ? gpts_pkg::off_hi_con
          : gpts_pkg::off_lo_con)) begin
        hit = 1'b1;
        next_prdata = {16'h0000, con[i]};
        con_wr[i] = wr;
      end
      if (paddr == pair_addr(i / 2, i[0] ? gpts_pkg::off_hi_cnt
          : gpts_pkg::off_lo_cnt)) begin
        hit = 1'b1;
        next_prdata = {16'h0000, cnt[i]};
        cnt_wr[i] = wr;
      end
      if (paddr == pair_addr(i / 2, i[0] ? gpts_pkg::off_hi_per
          : gpts_pkg::off_lo_per)) begin
        hit = 1'b1;
        next_prdata = {16'h0000, per[i]};
        per_wr[i] = wr;
      end
    end
    next_err = !hit;
  end

  // bus answer, one wait state
  always_ff @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && next_err;
      if (rd) begin
        prdata <= next_err ? 32'h0000_0000 : next_prdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_en <= 5'h00;
    end else if (wr && paddr == gpts_pkg::off_irq_en) begin
      irq_en <= pwdata[4:0];
    end
  end

  // standalone timer
  logic t1_ext_d;
  logic t1_ext_s1;
  logic t1_ext_s2;
  logic t1_ext_s3;
  logic t1_gate_d;
  logic [7:0] t1_ps;
  logic t1_raw_edge;
  logic t1_sync_edge;
  logic t1_in_tick;
  logic t1_run;
  logic t1_tick;
  logic t1_match;
  logic t1_gate_fall;
  logic t1_gated;

  always_ff @(posedge clock) begin
    if (rst) begin
      t1_ext_d <= 1'b0;
      t1_ext_s1 <= 1'b0;
      t1_ext_s2 <= 1'b0;
      t1_ext_s3 <= 1'b0;
      t1_gate_d <= 1'b0;
    end else begin
      t1_ext_d <= standalone_in.ext_clk;
      t1_ext_s1 <= standalone_in.ext_clk;
      t1_ext_s2 <= t1_ext_s1;
      t1_ext_s3 <= t1_ext_s2;
      t1_gate_d <= standalone_in.gate;
    end
  end

  always_comb begin
    t1_raw_edge = standalone_in.ext_clk && !t1_ext_d;
    t1_sync_edge = t1_ext_s2 && !t1_ext_s3;
    t1_gated = !standalone_timer_control[gpts_pkg::bit_cs]
      && standalone_timer_control[gpts_pkg::bit_gate];
    // asynchronous counting ignores idle
    t1_run = standalone_timer_control[gpts_pkg::bit_on]
      && !(device_idle && standalone_timer_control[gpts_pkg::bit_sidl]
        && !(standalone_timer_control[gpts_pkg::bit_cs]
          && !standalone_timer_control[gpts_pkg::bit_sync]));
    if (standalone_timer_control[gpts_pkg::bit_cs]) begin
      t1_in_tick = standalone_timer_control[gpts_pkg::bit_sync]
        ? t1_sync_edge : t1_raw_edge;
    end else begin
      t1_in_tick = !t1_gated || standalone_in.gate;
    end
    t1_tick = t1_run && t1_in_tick && t1_ps == ps_limit(
      standalone_timer_control[gpts_pkg::bit_ps_hi:gpts_pkg::bit_ps_lo]);
    t1_match = t1_tick && t1_cnt == standalone_period;
    t1_gate_fall = t1_run && t1_gated && t1_gate_d && !standalone_in.gate;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      t1_ps <= 8'h00;
    end else if (t1_con_wr && standalone_timer_control[gpts_pkg::bit_on]) begin
      t1_ps <= 8'h00;
    end else if (t1_run && t1_in_tick) begin
      t1_ps <= t1_tick ? 8'h00 : 8'(t1_ps + 8'h01);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      standalone_timer_control <= gpts_pkg::con_reset;
      standalone_period <= gpts_pkg::per_reset;
    end else begin
      if (t1_con_wr) begin
        standalone_timer_control <= pwdata[15:0] & gpts_pkg::t1_con_mask;
      end
      if (t1_per_wr) begin
        standalone_period <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      t1_cnt <= gpts_pkg::cnt_reset;
    end else if (t1_cnt_wr) begin
      t1_cnt <= pwdata[15:0];
    end else if (t1_match) begin
      t1_cnt <= 16'h0000;
    end else if (t1_tick) begin
      t1_cnt <= 16'(t1_cnt + 16'h0001);
    end
  end

  // pair timers; index 2p is low, 2p+1 is high
  logic [3:0] ext_d;
  logic [3:0] gate_d;
  logic [7:0] ps [0:3];
  logic [3:0] run;
  logic [3:0] in_tick;
  logic [3:0] tick;
  logic [3:0] match;
  logic [3:0] gfall;
  logic [15:0] next_cnt [0:3];
  logic [1:0] joined;
  logic [1:0] adc_evt;

  generate
    for (genvar i = 0; i < 4; i++) begin : g_tmr
      localparam int lo = i - (i % 2);
      localparam int pr = i / 2;
      logic [15:0] c;
      gpts_pkg::gpts_tin_t tin;
      logic gated;
      logic ext_edge;
      logic ctl_wr;
      // joined pair takes control and inputs from the low timer
      assign c = joined[pr] ? con[lo] : con[i];
      assign tin = (joined[pr] || i % 2 == 0) ? pair_low_in[pr]
        : pair_high_in[pr];
      assign gated = !c[gpts_pkg::bit_cs] && c[gpts_pkg::bit_gate];
      // pair external clock is never synchronised; the raw edge is counted
      assign ext_edge = tin.ext_clk && !ext_d[i];
      assign ctl_wr = con_wr[lo] || (!joined[pr] && con_wr[i]);
      assign run[i] = c[gpts_pkg::bit_on]
        && !(device_idle && c[gpts_pkg::bit_sidl]);
      assign in_tick[i] = c[gpts_pkg::bit_cs] ? ext_edge
        : (!gated || tin.gate);
      assign tick[i] = run[i] && in_tick[i]
        && ps[i] == ps_limit(c[gpts_pkg::bit_ps_hi:gpts_pkg::bit_ps_lo]);
      assign match[i] = tick[i] && cnt[i] == per[i];
      assign gfall[i] = run[i] && gated && gate_d[i] && !tin.gate;
      assign next_cnt[i] = cnt_wr[i] ? pwdata[15:0] : match[i] ? 16'h0000
        : tick[i] ? 16'(cnt[i] + 16'h0001) : cnt[i];

      always_ff @(posedge clock) begin
        if (rst) begin
          ext_d[i] <= 1'b0;
          gate_d[i] <= 1'b0;
        end else begin
          ext_d[i] <= tin.ext_clk;
          gate_d[i] <= tin.gate;
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          ps[i] <= 8'h00;
        end else if (ctl_wr && c[gpts_pkg::bit_on]) begin
          ps[i] <= 8'h00;
        end else if (run[i] && in_tick[i]) begin
          ps[i] <= tick[i] ? 8'h00 : 8'(ps[i] + 8'h01);
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          con[i] <= gpts_pkg::con_reset;
          per[i] <= gpts_pkg::per_reset;
        end else begin
          if (con_wr[i]) begin
            con[i] <= pwdata[15:0] & ((i % 2 == 0) ? gpts_pkg::lo_con_mask
              : gpts_pkg::hi_con_mask);
          end
          if (per_wr[i]) begin
            per[i] <= pwdata[15:0];
          end
        end
      end
    end

    for (genvar p = 0; p < 2; p++) begin : g_pair
      logic [31:0] c32;
      logic [31:0] p32;
      logic t32;
      logic m32;
      assign joined[p] = con[2*p][gpts_pkg::bit_join];
      assign c32 = {cnt[2*p+1], cnt[2*p]};
      assign p32 = {per[2*p+1], per[2*p]};
      assign t32 = tick[2*p];
      assign m32 = t32 && c32 == p32;

      always_ff @(posedge clock) begin
        if (rst) begin
          cnt[2*p] <= gpts_pkg::cnt_reset;
          cnt[2*p+1] <= gpts_pkg::cnt_reset;
        end else if (joined[p]) begin
          if (cnt_wr[2*p]) begin
            cnt[2*p] <= pwdata[15:0];
          end else if (cnt_wr[2*p+1]) begin
            cnt[2*p+1] <= pwdata[15:0];
          end else if (m32) begin
            cnt[2*p] <= 16'h0000;
            cnt[2*p+1] <= 16'h0000;
          end else if (t32) begin
            {cnt[2*p+1], cnt[2*p]} <= 32'(c32 + 32'h0000_0001);
          end
        end else begin
          cnt[2*p] <= next_cnt[2*p];
          cnt[2*p+1] <= next_cnt[2*p+1];
        end
      end
      assign adc_evt[p] = joined[p] ? m32 : match[2*p+1];
    end
  endgenerate

  // flags: bit0 standalone, 1 low0, 2 high0, 3 low1, 4 high1; set wins
  logic [4:0] set;
  always_comb begin
    set[0] = t1_match || t1_gate_fall;
    for (int p = 0; p < 2; p++) begin
      if (joined[p]) begin
        set[2*p+1] = 1'b0;
        set[2*p+2] = (tick[2*p] && {cnt[2*p+1], cnt[2*p]}
          == {per[2*p+1], per[2*p]}) || gfall[2*p];
      end else begin
        set[2*p+1] = match[2*p] || gfall[2*p];
        set[2*p+2] = match[2*p+1] || gfall[2*p+1];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flag <= 5'h00;
    end else begin
      flag <= (flag & ~clr) | set;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_flags <= 5'h00;
      adc_trigger <= 1'b0;
    end else begin
      irq_flags <= ((flag & ~clr) | set) & standalone_irq_enable;
      adc_trigger <= adc_evt[0];
    end
  end
endmodule
`default_nettype wire

// >>> gpts_props.sv
// assertion checker for the timer set bus and outputs
`timescale 1ns/1ps
`default_nettype none
module gpts_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic device_idle,
  input wire gpts_pkg::gpts_tin_t standalone_in,
  input wire gpts_pkg::gpts_tin_t [1:0] pair_low_in,
  input wire gpts_pkg::gpts_tin_t [1:0] pair_high_in,
  input wire logic [4:0] irq_flags,
  input wire logic adc_trigger
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_setup_access;
    psel && !penable && !pready ##1 psel && penable;
  endsequence
  sequence s_first_access;
    psel && penable && !pready;
  endsequence
  property p_wait;
    s_setup_access |=> pready;
  endproperty
  property p_pulse;
    pready |=> !pready;
  endproperty
  property p_cause;
    $rose(pready) |-> $past(psel && penable);
  endproperty
  property p_err;
    pslverr |-> pready;
  endproperty
  property p_unmapped;
    s_first_access and !pwrite && paddr == 12'h0fc |=>
      pslverr && prdata == 32'h0;
  endproperty
  property p_mapped;
    s_first_access and paddr == gpts_pkg::off_t1_cnt |=> !pslverr;
  endproperty
  property p_rdhold;
    $changed(prdata) |-> pready && !pwrite;
  endproperty
  property p_reset_out;
    $fell(rst) |-> irq_flags == 5'h00 && !adc_trigger && !pready;
  endproperty
  a_wait: assert property (p_wait)
    else $error("no answer one cycle after access");
  a_pulse: assert property (p_pulse)
    else $error("ready longer than one cycle");
  a_cause: assert property (p_cause)
    else $error("ready without access");
  a_err: assert property (p_err)
    else $error("error without ready");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
  a_mapped: assert property (p_mapped)
    else $error("mapped access refused");
  a_rdhold: assert property (p_rdhold)
    else $error("read data changed outside a read");
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not cleared by reset");
endmodule
bind gpts_top gpts_props u_props (.clock(clock), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .device_idle(device_idle), .standalone_in(standalone_in),
  .pair_low_in(pair_low_in), .pair_high_in(pair_high_in),
  .irq_flags(irq_flags), .adc_trigger(adc_trigger));
`default_nettype wire

// >>> gpts_bench.sv
// self-checking bench for the general purpose timer set
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module gpts_bench;
  localparam logic [11:0] p0 = gpts_pkg::off_pair_base;
  localparam logic [11:0] p1 = p0 + gpts_pkg::pair_stride;
  logic clock, rst, psel, penable, pwrite, pready, pslverr;
  logic device_idle, adc_trigger, er;
  logic [11:0] paddr, a;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [4:0] irq_flags;
  logic [15:0] v;
  gpts_pkg::gpts_tin_t standalone_in;
  gpts_pkg::gpts_tin_t [1:0] pair_low_in, pair_high_in;
  int err_count = 0, checked = 0, cyc = 0, n, p, adc_cnt = 0;
  logic [11:0] ra [5] = '{gpts_pkg::off_t1_con, gpts_pkg::off_t1_cnt,
    gpts_pkg::off_t1_per, p0 + gpts_pkg::off_lo_con,
    p1 + gpts_pkg::off_hi_per};
  logic [15:0] rv [5] = '{16'h0000, 16'h0000, 16'hffff, 16'h0000, 16'hffff};
  logic [11:0] ca [3] = '{gpts_pkg::off_t1_con, p0 + gpts_pkg::off_lo_con,
    p0 + gpts_pkg::off_hi_con};
  logic [15:0] cm [3] = '{gpts_pkg::t1_con_mask, gpts_pkg::lo_con_mask,
    gpts_pkg::hi_con_mask};
  gpts_top dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .device_idle(device_idle),
    .standalone_in(standalone_in), .pair_low_in(pair_low_in),
    .pair_high_in(pair_high_in), .irq_flags(irq_flags),
    .adc_trigger(adc_trigger));
  initial begin
    clock = 0;
    forever #10 clock = ~clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic int divr(input int c);
    return c == 3 ? 256 : c == 2 ? 64 : c == 1 ? 8 : 1;
  endfunction
  task automatic end_sim;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (adc_trigger === 1'b1) adc_cnt <= adc_cnt + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim;
    end
  end
  task automatic apb(input logic w, input logic [11:0] ad,
      input logic [31:0] d);
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task automatic rdv(input logic [11:0] ad);
    apb(1'b0, ad, 32'h0);
  endtask
  task automatic wait_irq(input int b);
    n = 0;
    while (irq_flags[b] !== 1'b1 && n < 300) begin
      @(posedge clock);
      n++;
    end
  endtask
  task automatic ext_run(input logic [11:0] con, input logic [11:0] cnt,
      input logic [15:0] cv, input int w);
    wr(cnt, 32'h0);
    wr(con, {16'h0, cv});
    repeat (5) begin
      repeat (3) @(posedge clock);
      if (w) pair_low_in[1].ext_clk <= 1; else standalone_in.ext_clk <= 1;
      repeat (3) @(posedge clock);
      if (w) pair_low_in[1].ext_clk <= 0; else standalone_in.ext_clk <= 0;
    end
    repeat (6) @(posedge clock);
    rdv(cnt);
    `CHK(rd[15:0], 16'd5)
    wr(con, 32'h0);
  endtask
  initial begin
    rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    device_idle = 0; standalone_in = 0; pair_low_in = 0; pair_high_in = 0;
    seed = 32'h6d0495db;
    repeat (5) @(posedge clock);
    rst <= 0;
    for (int i = 0; i < 5; i++) begin
      rdv(ra[i]);
      `CHK(rd, {16'h0, rv[i]})
    end
    for (int i = 0; i < 3; i++) begin
      wr(ca[i], 32'hffffffff);
      rdv(ca[i]);
      `CHK(rd, {16'h0, cm[i]})
      wr(ca[i], 32'h0);
    end
    wr(12'h0fc, 32'hffffffff);
    `CHK(er, 1'b1)
    rdv(12'h0fc);
    `CHK({er, rd}, {1'b1, 32'h0})
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      pair_low_in[0] <= seed[9:8];
      pair_high_in <= seed[13:10];
      a = (seed[0] ? p1 : p0) + (seed[1] ? gpts_pkg::off_hi_per
        : seed[2] ? gpts_pkg::off_lo_cnt : gpts_pkg::off_lo_per);
      wr(a, seed);
      rdv(a);
      `CHK(rd, {16'h0, seed[15:0]})
    end
    for (int c = 0; c < 4; c++) begin
      wr(gpts_pkg::off_t1_per, 32'hffff);
      wr(gpts_pkg::off_t1_cnt, 32'h0);
      wr(gpts_pkg::off_t1_con, 32'h8000 | (c << 4));
      repeat (divr(c) * 8) @(posedge clock);
      wr(gpts_pkg::off_t1_con, c << 4);
      rdv(gpts_pkg::off_t1_cnt);
      v = rd[15:0];
      `CHK(v >= 8 && v <= 8 + 12 / divr(c), 1'b1)
      rdv(gpts_pkg::off_t1_cnt);
      `CHK(rd[15:0], v)
    end
    wr(gpts_pkg::off_irq_en, 32'h1f);
    p = 4 + seed[3:0];
    wr(gpts_pkg::off_t1_per, p);
    wr(gpts_pkg::off_t1_cnt, 32'h0);
    wr(gpts_pkg::off_t1_con, 32'h8000);
    wait_irq(0);
    `CHK(n >= p - 2 && n <= p + 4, 1'b1)
    wr(gpts_pkg::off_t1_con, 32'h0);
    wr(gpts_pkg::off_status, 32'h1f);
    @(posedge clock);
    `CHK(irq_flags[0], 1'b0)
    wr(p0 + gpts_pkg::off_lo_cnt, 32'hfff0);
    wr(p0 + gpts_pkg::off_hi_cnt, 32'h0);
    wr(p0 + gpts_pkg::off_lo_per, 32'h4);
    wr(p0 + gpts_pkg::off_hi_per, 32'h1);
    wr(p0 + gpts_pkg::off_hi_con, 32'h8030);
    adc_cnt = 0;
    wr(p0 + gpts_pkg::off_lo_con, 32'h8008);
    wait_irq(2);
    `CHK(n >= 16 && n <= 26, 1'b1)
    `CHK(irq_flags[1], 1'b0)
    wr(p0 + gpts_pkg::off_lo_con, 32'h8);
    rdv(p0 + gpts_pkg::off_hi_cnt);
    `CHK(rd[15:0], 16'h0)
    `CHK(adc_cnt > 0, 1'b1)
    wr(gpts_pkg::off_status, 32'h1f);
    wr(gpts_pkg::off_t1_per, 32'hffff);
    wr(gpts_pkg::off_t1_cnt, 32'h0);
    wr(gpts_pkg::off_t1_con, 32'h8040);
    repeat (20) @(posedge clock);
    rdv(gpts_pkg::off_t1_cnt);
    `CHK(rd[15:0], 16'h0)
    standalone_in.gate <= 1;
    repeat (20) @(posedge clock);
    standalone_in.gate <= 0;
    repeat (4) @(posedge clock);
    rdv(gpts_pkg::off_t1_cnt);
    `CHK(rd[15:0] >= 17 && rd[15:0] <= 23, 1'b1)
    `CHK(irq_flags[0], 1'b1)
    wr(gpts_pkg::off_t1_con, 32'ha000);
    device_idle <= 1;
    repeat (10) @(posedge clock);
    rdv(gpts_pkg::off_t1_cnt);
    v = rd[15:0];
    repeat (10) @(posedge clock);
    rdv(gpts_pkg::off_t1_cnt);
    `CHK(rd[15:0], v)
    device_idle <= 0;
    repeat (10) @(posedge clock);
    rdv(gpts_pkg::off_t1_cnt);
    `CHK(rd[15:0] > v, 1'b1)
    wr(gpts_pkg::off_t1_con, 32'h0);
    ext_run(gpts_pkg::off_t1_con, gpts_pkg::off_t1_cnt, 16'h8006, 0);
    ext_run(gpts_pkg::off_t1_con, gpts_pkg::off_t1_cnt, 16'h8002, 0);
    wr(p1 + gpts_pkg::off_lo_per, 32'hffff);
    ext_run(p1 + gpts_pkg::off_lo_con, p1 + gpts_pkg::off_lo_cnt,
      16'h8002, 1);
    end_sim;
  end
endmodule
`default_nettype wire
